// ===== shared/ddr_read_pkg.sv
// Constants, field layouts and state codes for the double-data-rate quad read block.
package ddr_read_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the Wishbone bus)
  // ----------------------------------------------------------------
  localparam int          WB_ADR_W       = 8;
  localparam logic [7:0]  REG_CONFIG     = 8'h00;
  localparam logic [7:0]  REG_BANK       = 8'h04;
  localparam logic [7:0]  REG_LEARN_CTRL = 8'h08;
  localparam logic [7:0]  REG_LEARN_PAT  = 8'h0c;
  localparam logic [7:0]  REG_STATUS     = 8'h10;
  localparam logic [7:0]  REG_ADDR       = 8'h14;
  localparam logic [7:0]  REG_ARR_IDX    = 8'h18;
  localparam logic [7:0]  REG_ARR_DATA   = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CFG_QUAD_BIT     = 1;
  localparam int          CFG_LC_LSB       = 6;
  localparam int          BANK_EXT_BIT     = 7;
  localparam int          LEARN_EN_BIT     = 0;
  localparam int          STAT_CONT_BIT    = 0;
  localparam int          STAT_BUSY_BIT    = 1;
  localparam int          STAT_STATE_LSB   = 8;
  localparam logic [7:0]  CFG_RESET        = 8'h00;
  localparam logic [7:0]  BANK_RESET       = 8'h00;
  localparam logic        LEARN_EN_RESET   = 1'b0;
  localparam logic [7:0]  LEARN_PAT_RESET  = 8'h34;

  // ----------------------------------------------------------------
  // Command encodings and sequence lengths
  // ----------------------------------------------------------------
  localparam logic [7:0]  OP_READ_AUTO     = 8'hed;
  localparam logic [7:0]  OP_READ_WIDE     = 8'hee;
  localparam logic [5:0]  OPCODE_BITS      = 6'h08;
  localparam logic [5:0]  ADDR_NIB_NARROW  = 6'h06;
  localparam logic [5:0]  ADDR_NIB_WIDE    = 6'h08;
  localparam logic [5:0]  MODE_NIBS        = 6'h02;
  localparam logic [5:0]  PREAMBLE_EDGES   = 6'h08;
  localparam logic [4:0]  RELEASE_MAX_RISE = 5'h08;

  // Dummy cycle count for each latency code; every entry covers the preamble.
  localparam logic [4:0]  LAT_CODE0 = 5'h05;
  localparam logic [4:0]  LAT_CODE1 = 5'h06;
  localparam logic [4:0]  LAT_CODE2 = 5'h07;
  localparam logic [4:0]  LAT_CODE3 = 5'h08;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int          ARRAY_IDX_W = 6;
  localparam int          ARRAY_DEPTH = 64;
  localparam logic [31:0] ARRAY_TOP   = 32'h0000003f;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_OPCODE = 7'h02,
    ST_ADDR   = 7'h04,
    ST_MODE   = 7'h08,
    ST_DUMMY  = 7'h10,
    ST_DATA   = 7'h20,
    ST_IGNORE = 7'h40
  } read_state_t;

  function automatic logic [4:0] lat_cycles(input logic [1:0] code);
    logic [4:0] n;
    unique case (code)
      2'h0: n = LAT_CODE0;
      2'h1: n = LAT_CODE1;
      2'h2: n = LAT_CODE2;
      2'h3: n = LAT_CODE3;
    endcase
    return n;
  endfunction

endpackage

// ===== hw/sync_bits.sv
// Two-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/1ps
module sync_bits #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_nxt;

  always_comb
  begin
    meta_nxt = ce_i ? d_i : meta_r;
    q_nxt    = ce_i ? meta_r : q_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= RESET_VAL;
      q_o    <= RESET_VAL;
    end
    else
    begin
      meta_r <= meta_nxt;
      q_o    <= q_nxt;
    end
  end

endmodule

// ===== hw/cell_array.sv
// Byte array in flip-flops with one write port and two read ports.
`timescale 1ns/1ps
module cell_array (
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  input  wire logic                                ce_i,
  input  wire logic                                wr_en_i,
  input  wire logic [ddr_read_pkg::ARRAY_IDX_W-1:0] wr_idx_i,
  input  wire logic [7:0]                          wr_data_i,
  input  wire logic [ddr_read_pkg::ARRAY_IDX_W-1:0] rd_a_idx_i,
  output logic      [7:0]                          rd_a_data_o,
  input  wire logic [ddr_read_pkg::ARRAY_IDX_W-1:0] rd_b_idx_i,
  output logic      [7:0]                          rd_b_data_o
);

  logic [7:0] cell_r   [ddr_read_pkg::ARRAY_DEPTH];
  logic [7:0] cell_nxt [ddr_read_pkg::ARRAY_DEPTH];

  for (genvar i = 0; i < ddr_read_pkg::ARRAY_DEPTH; i++)
  begin : g_cell
    always_comb
    begin
      cell_nxt[i] = cell_r[i];
      if (ce_i && wr_en_i && (32'(wr_idx_i) == i))
        cell_nxt[i] = wr_data_i;
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        cell_r[i] <= 8'hff;
      else
        cell_r[i] <= cell_nxt[i];
    end
  end

  assign rd_a_data_o = cell_r[rd_a_idx_i];
  assign rd_b_data_o = cell_r[rd_b_idx_i];

endmodule

// ===== hw/ddr_quad_io_read.sv
// Double-data-rate quad read command path of a serial flash with a Wishbone register port.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module ddr_quad_io_read (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic       sclk_s;
  logic       cs_n_s;
  logic [3:0] io_s;
  logic       sclk_d_r;
  logic       cs_d_r;

  sync_bits #(
    .WIDTH     (6),
    .RESET_VAL (6'h10)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({sclk_i, cs_n_i, io_i}),
    .q_o   ({sclk_s, cs_n_s, io_s})
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
    end
    else if (ce_i)
    begin
      sclk_d_r <= sclk_s;
      cs_d_r   <= cs_n_s;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic sclk_edge;
  logic cs_fall;
  logic cs_rise;

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;
  assign sclk_edge = sclk_rise | sclk_fall;
  assign cs_fall   = ~cs_n_s & cs_d_r;
  assign cs_rise   = cs_n_s & ~cs_d_r;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [7:0]  config_reg_one_r;
  logic [7:0]  config_reg_one_nxt;
  logic [7:0]  bank_r;
  logic [7:0]  bank_nxt;
  logic        learn_en_r;
  logic        learn_en_nxt;
  logic [7:0]  learning_pattern_r;
  logic [7:0]  learning_pattern_nxt;
  logic [ddr_read_pkg::ARRAY_IDX_W-1:0] arr_idx_r;
  logic [ddr_read_pkg::ARRAY_IDX_W-1:0] arr_idx_nxt;
  logic [31:0] rdat_nxt;
  logic        ack_nxt;
  logic        wb_take;
  logic        wb_commit;
  logic        arr_wr;
  logic [7:0]  arr_wb_data;

  logic        quad_enable;
  logic        extended_address_bit;
  logic [1:0]  latency_code_field;

  assign quad_enable          = config_reg_one_r[ddr_read_pkg::CFG_QUAD_BIT];
  assign extended_address_bit = bank_r[ddr_read_pkg::BANK_EXT_BIT];
  assign latency_code_field   = config_reg_one_r[ddr_read_pkg::CFG_LC_LSB +: 2];

  // Status and address are read-only views of the command path.
  ddr_read_pkg::read_state_t state_r;
  logic                      cont_r;
  logic [31:0]               addr_r;

  assign wb_take   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_commit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign arr_wr    = wb_commit && (wb_adr_i == ddr_read_pkg::REG_ARR_DATA);

  always_comb
  begin
    ack_nxt              = wb_take;
    rdat_nxt             = wb_dat_o;
    config_reg_one_nxt   = config_reg_one_r;
    bank_nxt             = bank_r;
    learn_en_nxt         = learn_en_r;
    learning_pattern_nxt = learning_pattern_r;
    arr_idx_nxt          = arr_idx_r;
    if (wb_take)
    begin
      rdat_nxt = 32'h00000000;
      unique case (wb_adr_i)
        ddr_read_pkg::REG_CONFIG:     rdat_nxt[7:0] = config_reg_one_r;
        ddr_read_pkg::REG_BANK:       rdat_nxt[7:0] = bank_r;
        ddr_read_pkg::REG_LEARN_CTRL: rdat_nxt[ddr_read_pkg::LEARN_EN_BIT] = learn_en_r;
        ddr_read_pkg::REG_LEARN_PAT:  rdat_nxt[7:0] = learning_pattern_r;
        ddr_read_pkg::REG_STATUS:
        begin
          rdat_nxt[ddr_read_pkg::STAT_CONT_BIT]       = cont_r;
          rdat_nxt[ddr_read_pkg::STAT_BUSY_BIT]       = ~cs_n_s;
          rdat_nxt[ddr_read_pkg::STAT_STATE_LSB +: 7] = state_r;
        end
        ddr_read_pkg::REG_ADDR:       rdat_nxt = addr_r;
        ddr_read_pkg::REG_ARR_IDX:    rdat_nxt[ddr_read_pkg::ARRAY_IDX_W-1:0] = arr_idx_r;
        ddr_read_pkg::REG_ARR_DATA:   rdat_nxt[7:0] = arr_wb_data;
        default:                      rdat_nxt = 32'h00000000;
      endcase
    end
    if (wb_commit)
    begin
      unique case (wb_adr_i)
        ddr_read_pkg::REG_CONFIG:     config_reg_one_nxt   = wb_dat_i[7:0];
        ddr_read_pkg::REG_BANK:       bank_nxt             = wb_dat_i[7:0];
        ddr_read_pkg::REG_LEARN_CTRL: learn_en_nxt         = wb_dat_i[ddr_read_pkg::LEARN_EN_BIT];
        ddr_read_pkg::REG_LEARN_PAT:  learning_pattern_nxt = wb_dat_i[7:0];
        ddr_read_pkg::REG_ARR_IDX:    arr_idx_nxt          = wb_dat_i[ddr_read_pkg::ARRAY_IDX_W-1:0];
        default:                      arr_idx_nxt          = arr_idx_r;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o           <= 1'b0;
      wb_dat_o           <= 32'h00000000;
      config_reg_one_r   <= ddr_read_pkg::CFG_RESET;
      bank_r             <= ddr_read_pkg::BANK_RESET;
      learn_en_r         <= ddr_read_pkg::LEARN_EN_RESET;
      learning_pattern_r <= ddr_read_pkg::LEARN_PAT_RESET;
      arr_idx_r          <= '0;
    end
    else if (ce_i)
    begin
      wb_ack_o           <= ack_nxt;
      wb_dat_o           <= rdat_nxt;
      config_reg_one_r   <= config_reg_one_nxt;
      bank_r             <= bank_nxt;
      learn_en_r         <= learn_en_nxt;
      learning_pattern_r <= learning_pattern_nxt;
      arr_idx_r          <= arr_idx_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Memory array
  // ----------------------------------------------------------------
  logic [7:0] arr_byte;

  cell_array u_array (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .wr_en_i     (arr_wr),
    .wr_idx_i    (arr_idx_r),
    .wr_data_i   (wb_dat_i[7:0]),
    .rd_a_idx_i  (addr_r[ddr_read_pkg::ARRAY_IDX_W-1:0]),
    .rd_a_data_o (arr_byte),
    .rd_b_idx_i  (arr_idx_r),
    .rd_b_data_o (arr_wb_data)
  );

  // ----------------------------------------------------------------
  // Serial command sequencer
  // ----------------------------------------------------------------
  ddr_read_pkg::read_state_t state_nxt;
  logic        cont_nxt;
  logic        cont_pend_r;
  logic        cont_pend_nxt;
  logic        cont_wide_r;
  logic        cont_wide_nxt;
  logic        valid_r;
  logic        valid_nxt;
  logic [4:0]  rise_cnt_r;
  logic [4:0]  rise_cnt_nxt;
  logic [5:0]  cnt_r;
  logic [5:0]  cnt_nxt;
  logic [5:0]  addr_nibs_r;
  logic [5:0]  addr_nibs_nxt;
  logic [31:0] shift_r;
  logic [31:0] shift_nxt;
  logic [3:0]  mode_hi_r;
  logic [3:0]  mode_hi_nxt;
  logic        lo_next_r;
  logic        lo_next_nxt;
  logic [31:0] addr_nxt;
  logic [3:0]  io_nxt;
  logic        oe_nxt;
  logic [7:0]  opcode;
  logic [5:0]  dummy_edges;
  logic [5:0]  pre_start;
  logic [5:0]  pre_pos;
  logic        wide_req;

  assign opcode      = shift_r[7:0];
  assign dummy_edges = {ddr_read_pkg::lat_cycles(latency_code_field), 1'b0};
  assign pre_start   = dummy_edges - ddr_read_pkg::PREAMBLE_EDGES;
  assign pre_pos     = cnt_r - pre_start;
  assign wide_req    = (opcode == ddr_read_pkg::OP_READ_WIDE) || extended_address_bit;

  always_comb
  begin
    state_nxt     = state_r;
    cont_nxt      = cont_r;
    cont_pend_nxt = cont_pend_r;
    cont_wide_nxt = cont_wide_r;
    valid_nxt     = valid_r;
    rise_cnt_nxt  = rise_cnt_r;
    cnt_nxt       = cnt_r;
    addr_nibs_nxt = addr_nibs_r;
    shift_nxt     = shift_r;
    mode_hi_nxt   = mode_hi_r;
    lo_next_nxt   = lo_next_r;
    addr_nxt      = addr_r;
    io_nxt        = io_o;
    oe_nxt        = io_oe_o[0];
    if (cs_n_s)
    begin
      state_nxt = ddr_read_pkg::ST_IDLE;
      oe_nxt    = 1'b0;
      if (cs_rise)
      begin
        if (valid_r)
          cont_nxt = cont_pend_r;
        else if (rise_cnt_r <= ddr_read_pkg::RELEASE_MAX_RISE)
          cont_nxt = 1'b0;
      end
    end
    else
    begin
      if (sclk_rise && (rise_cnt_r <= ddr_read_pkg::RELEASE_MAX_RISE))
        rise_cnt_nxt = rise_cnt_r + 5'h01;
      unique case (state_r)
        ddr_read_pkg::ST_IDLE:
        begin
          cnt_nxt      = 6'h00;
          shift_nxt    = 32'h00000000;
          rise_cnt_nxt = 5'h00;
          valid_nxt    = 1'b0;
          lo_next_nxt  = 1'b0;
          if (!cs_fall)
            state_nxt = ddr_read_pkg::ST_IGNORE;
          else if (cont_r && quad_enable)
          begin
            // A continuous series skips the opcode and keeps the earlier address width.
            state_nxt     = ddr_read_pkg::ST_ADDR;
            addr_nibs_nxt = cont_wide_r ? ddr_read_pkg::ADDR_NIB_WIDE : ddr_read_pkg::ADDR_NIB_NARROW;
          end
          else
            state_nxt = ddr_read_pkg::ST_OPCODE;
        end
        ddr_read_pkg::ST_OPCODE:
        begin
          if (sclk_rise)
          begin
            shift_nxt = {shift_r[30:0], io_s[0]};
            cnt_nxt   = cnt_r + 6'h01;
          end
          // The eighth opcode cycle ends on its falling edge; the address starts on the next rising edge.
          if (sclk_fall && (cnt_r == ddr_read_pkg::OPCODE_BITS))
          begin
            cnt_nxt = 6'h00;
            if (((opcode == ddr_read_pkg::OP_READ_AUTO) || (opcode == ddr_read_pkg::OP_READ_WIDE))
                && quad_enable)
            begin
              state_nxt     = ddr_read_pkg::ST_ADDR;
              cont_wide_nxt = wide_req;
              addr_nibs_nxt = wide_req ? ddr_read_pkg::ADDR_NIB_WIDE
                                       : ddr_read_pkg::ADDR_NIB_NARROW;
            end
            else
              state_nxt = ddr_read_pkg::ST_IGNORE;
          end
        end
        ddr_read_pkg::ST_ADDR:
        begin
          if (sclk_edge)
          begin
            shift_nxt = {shift_r[27:0], io_s};
            cnt_nxt   = cnt_r + 6'h01;
            if (cnt_r == addr_nibs_r - 6'h01)
            begin
              cnt_nxt   = 6'h00;
              state_nxt = ddr_read_pkg::ST_MODE;
              if (addr_nibs_r == ddr_read_pkg::ADDR_NIB_WIDE)
                addr_nxt = {shift_r[27:0], io_s};
              else
                addr_nxt = {8'h00, shift_r[19:0], io_s};
            end
          end
        end
        ddr_read_pkg::ST_MODE:
        begin
          if (sclk_edge)
          begin
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r == 6'h00)
              mode_hi_nxt = io_s;
            if (cnt_r == ddr_read_pkg::MODE_NIBS - 6'h01)
            begin
              cnt_nxt       = 6'h00;
              valid_nxt     = 1'b1;
              cont_pend_nxt = (mode_hi_r == ~io_s);
              state_nxt     = ddr_read_pkg::ST_DUMMY;
            end
          end
        end
        ddr_read_pkg::ST_DUMMY:
        begin
          if (sclk_edge)
          begin
            cnt_nxt = cnt_r + 6'h01;
            if (learn_en_r && (cnt_r >= pre_start))
            begin
              oe_nxt = 1'b1;
              io_nxt = {4{learning_pattern_r[3'h7 - pre_pos[2:0]]}};
            end
            if (cnt_r == dummy_edges - 6'h01)
              state_nxt = ddr_read_pkg::ST_DATA;
          end
        end
        ddr_read_pkg::ST_DATA:
        begin
          // IO3 carries data here and is never taken as a pause request.
          if (sclk_edge)
          begin
            oe_nxt      = 1'b1;
            lo_next_nxt = ~lo_next_r;
            if (!lo_next_r)
              io_nxt = arr_byte[7:4];
            else
            begin
              io_nxt = arr_byte[3:0];
              if (addr_r >= ddr_read_pkg::ARRAY_TOP)
                addr_nxt = 32'h00000000;
              else
                addr_nxt = addr_r + 32'h00000001;
            end
          end
        end
        ddr_read_pkg::ST_IGNORE:
        begin
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r     <= ddr_read_pkg::ST_IDLE;
      cont_r      <= 1'b0;
      cont_pend_r <= 1'b0;
      cont_wide_r <= 1'b0;
      valid_r     <= 1'b0;
      rise_cnt_r  <= 5'h00;
      cnt_r       <= 6'h00;
      addr_nibs_r <= ddr_read_pkg::ADDR_NIB_NARROW;
      shift_r     <= 32'h00000000;
      mode_hi_r   <= 4'h0;
      lo_next_r   <= 1'b0;
      addr_r      <= 32'h00000000;
      io_o        <= 4'h0;
      io_oe_o     <= 4'h0;
    end
    else if (ce_i)
    begin
      state_r     <= state_nxt;
      cont_r      <= cont_nxt;
      cont_pend_r <= cont_pend_nxt;
      cont_wide_r <= cont_wide_nxt;
      valid_r     <= valid_nxt;
      rise_cnt_r  <= rise_cnt_nxt;
      cnt_r       <= cnt_nxt;
      addr_nibs_r <= addr_nibs_nxt;
      shift_r     <= shift_nxt;
      mode_hi_r   <= mode_hi_nxt;
      lo_next_r   <= lo_next_nxt;
      addr_r      <= addr_nxt;
      io_o        <= io_nxt;
      io_oe_o     <= {4{oe_nxt}};
    end
  end

endmodule

// ===== verification/ddr_quad_io_read_asserts.sv
// Port-level checks for the quad read block.
`timescale 1ns/1ps
module ddr_quad_io_read_asserts (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       sclk_i,
  input wire logic       cs_n_i,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o
);
  logic       sclk_q;
  logic [3:0] quiet_r;
  // Counts clocks since the serial clock pin last moved.
  always_ff @(posedge clk_i)
  begin
    sclk_q  <= sclk_i;
    quiet_r <= (rst_i || sclk_i != sclk_q) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no ack after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_oe_all; io_oe_o != 4'h0 |-> io_oe_o == 4'hf; endproperty
  a_oe_all: assert property (p_oe_all)
    else $error("lines not driven together");
  property p_oe_idle; cs_n_i [*6] |-> io_oe_o == 4'h0; endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("drive while deselected");
  property p_oe_rise; $rose(io_oe_o[0]) |-> !cs_n_i && !$past(cs_n_i, 4); endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("drive starts outside frame");
  property p_oe_fall; $fell(io_oe_o[0]) |-> $past(cs_n_i, 2); endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("drive ends inside frame");
  property p_io_edge; io_oe_o[0] && $changed(io_o) |-> quiet_r < 4'h6; endproperty
  a_io_edge: assert property (p_io_edge)
    else $error("output moved away from clock edge");
  c_ack: cover property (wb_ack_o && wb_cyc_i);
  c_drive: cover property ($rose(io_oe_o[0]));
  c_frame: cover property ($fell(cs_n_i));
endmodule
bind ddr_quad_io_read ddr_quad_io_read_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .io_o(io_o), .io_oe_o(io_oe_o));

// ===== verification/spi_host_model.sv
// Behavioural host controller that clocks frames into the quad read block.
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic [3:0] dev_io_i,
  input  wire logic [3:0] dev_oe_i,
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic [3:0]      io_o
);
  logic [3:0] drv = 4'h0;
  logic       drv_en = 1'b1;
  logic [3:0] cap[$];
  // Released lines have no pull, so they show the inverse of the last driven value.
  assign io_o = (dev_oe_i & dev_io_i) | (~dev_oe_i & (drv_en ? drv : ~drv));
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
  end
  // One half period of 100 ns; data changes midway between clock edges.
  task automatic step(input logic [3:0] v);
    drv = v;
    #50;
    cap.push_back(io_o);
    sclk_o = ~sclk_o;
    #50;
  endtask
  task automatic start();
    cap.delete();
    drv_en = 1'b1;
    cs_n_o = 1'b0;
    #100;
  endtask
  task automatic send_op(input logic [7:0] op);
    for (int i = 7; i >= 0; i--)
      repeat (2) step({3'h0, op[i]});
  endtask
  task automatic send_nibs(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      step(v[4 * i +: 4]);
  endtask
  task automatic listen(input int n);
    drv_en = 1'b0;
    repeat (n) step(drv);
  endtask
  task automatic stop();
    #100;
    cs_n_o = 1'b1;
    #500;
  endtask
endmodule

// ===== verification/test_ddr_quad_io_read.sv
// Self-checking bench for the quad read block.
`timescale 1ns/1ps
module test_ddr_quad_io_read;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q;
  logic [31:0] dat_o;
  logic        ack;
  logic        sclk;
  logic        cs_n;
  logic [3:0]  io_w;
  logic [3:0]  io_d;
  logic [3:0]  oe;
  logic        oe_seen = 1'b0;
  int          n_fail = 0;
  int          comparisons = 0;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (oe[0] === 1'b1) oe_seen <= 1'b1;
  ddr_quad_io_read dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .sclk_i(sclk), .cs_n_i(cs_n), .io_i(io_w), .io_o(io_d), .io_oe_o(oe));
  spi_host_model host_u (.dev_io_i(io_d), .dev_oe_i(oe), .sclk_o(sclk), .cs_n_o(cs_n), .io_o(io_w));
  task automatic results();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, we, sel, adr, dat} <= {1'b1, w, {4{w}}, a, d};
    for (n = 0; n < 10 && ack !== 1'b1; n++) @(posedge clk_i);
    q = dat_o;
    cyc <= 1'b0;
    if (n == 10)
    begin
      n_fail++;
      results();
    end
  endtask
  function automatic logic [7:0] mem(input logic [31:0] a);
    return {a[5:0], 2'h2} ^ 8'h5a;
  endfunction
  task automatic cfg(input logic [1:0] lc, input logic ext, input logic [7:0] pat);
    wb(1'b1, ddr_read_pkg::REG_CONFIG, 32'({lc, 6'h02}));
    wb(1'b1, ddr_read_pkg::REG_BANK, 32'({ext, 7'h0}));
    wb(1'b1, ddr_read_pkg::REG_LEARN_CTRL, 32'(pat != 8'h0));
    wb(1'b1, ddr_read_pkg::REG_LEARN_PAT, 32'(pat));
  endtask
  task automatic cont(input logic e);
    wb(1'b0, ddr_read_pkg::REG_STATUS, 32'h0);
    check(32'(q[0]), 32'(e));
  endtask
  task automatic rd(input logic op_en, input logic [7:0] op, input int nib, input logic [31:0] a,
                    input logic [7:0] mode, input int lat, input logic [7:0] pat, input logic ec);
    int          o;
    logic [31:0] ea;
    o  = (op_en ? 16 : 0) + nib + 2;
    ea = a;
    host_u.start();
    if (op_en)
      host_u.send_op(op);
    host_u.send_nibs(a, nib);
    host_u.send_nibs({24'h0, mode}, 2);
    host_u.listen(2 * lat + 8);
    host_u.stop();
    for (int j = 2 * lat - 7; j <= 2 * lat && pat != 8'h0; j++)
      check(32'(host_u.cap[o + j]), 32'({4{pat[2 * lat - j]}}));
    for (int b = 0; b < 3; b++)
    begin
      check(32'({host_u.cap[o + 2 * lat + 1 + 2 * b], host_u.cap[o + 2 * lat + 2 + 2 * b]}), 32'(mem(ea)));
      ea = (ea >= ddr_read_pkg::ARRAY_TOP) ? 32'h0 : ea + 32'h1;
    end
    cont(ec);
    $display("rd done");
  endtask
  task automatic t_regs();
    wb(1'b0, ddr_read_pkg::REG_CONFIG, 32'h0);
    check(q, 32'h0);
    wb(1'b0, ddr_read_pkg::REG_LEARN_PAT, 32'h0);
    check(q, 32'h34);
    wb(1'b0, 8'h40, 32'h0);
    check(q, 32'h0);
    for (int i = 0; i < 64; i++)
    begin
      wb(1'b1, ddr_read_pkg::REG_ARR_IDX, 32'(i));
      wb(1'b1, ddr_read_pkg::REG_ARR_DATA, 32'(mem(32'(i))));
    end
    $display("t_regs done");
  endtask
  task automatic t_off();
    oe_seen = 1'b0;
    host_u.start();
    host_u.send_op(8'hed);
    host_u.send_nibs(32'h0, 8);
    host_u.listen(20);
    host_u.stop();
    check(32'(oe_seen), 32'h0);
    $display("t_off done");
  endtask
  task automatic t_short();
    host_u.start();
    host_u.send_nibs(32'hffffffff, 6);
    host_u.stop();
    cont(1'b0);
    $display("t_short done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_off();
    cfg(2'h0, 1'b0, 8'h34);
    rd(1'b1, 8'hed, 6, 32'h3e, 8'h5a, 5, 8'h34, 1'b1);
    cfg(2'h2, 1'b0, 8'h00);
    rd(1'b0, 8'h00, 6, 32'h10, 8'h00, 7, 8'h00, 1'b0);
    cfg(2'h1, 1'b1, 8'h00);
    rd(1'b1, 8'hed, 8, 32'h12340021, 8'ha5, 6, 8'h00, 1'b1);
    t_short();
    cfg(2'h3, 1'b0, 8'hc3);
    rd(1'b1, 8'hee, 8, 32'hff000001, 8'h00, 8, 8'hc3, 1'b0);
    $display("reads done");
    results();
  end
endmodule
